// >>> amx_pkg.sv
/*
 * amx_pkg: shared constants and carrier types of the audio matrix mixer.
 * Assumes a 50 MHz bus clock and 24-bit two's complement audio words.
 */
package amx_pkg;

	// clock and channel structure
	localparam int CLK_HZ = 50_000_000;
	localparam int N_CH   = 28;
	localparam int DW     = 24;

	localparam logic [4:0] CH_LAST          = 5'h1B;
	localparam logic [4:0] CH_OPT_FIRST     = 5'h0A;
	localparam logic [4:0] CH_OPT_DBL_FIRST = 5'h12;
	localparam logic [4:0] CH_OPT_LAST      = 5'h19;
	localparam logic [4:0] CH_SPDIF_FIRST   = 5'h1A;
	localparam logic [3:0] PAIR_LAST        = 4'hD;

	// meter index space: inputs, then playback, then outputs
	localparam int         N_METER         = 84;
	localparam logic [6:0] PLAY_METER_BASE = 7'h1C;
	localparam logic [6:0] POST_METER_BASE = 7'h38;
	localparam int         RMS_SHIFT       = 12;

	// gain: unsigned, 16'h8000 is unity; pan: 0 full left, FF full right
	localparam int         GAIN_FRAC  = 15;
	localparam logic [7:0] PAN_MAX    = 8'hFF;
	localparam logic [15:0] OUTLVL_RST = 16'h8000;

	// timing
	localparam int LOCK_TIMEOUT_US = 100;
	localparam int LOCK_CYCLES     = LOCK_TIMEOUT_US * (CLK_HZ / 1_000_000);
	localparam int GATE_MS         = 100;
	localparam int GATE_CYCLES     = GATE_MS * (CLK_HZ / 1000);
	localparam logic [31:0] FREQ_SCALE = 32'(1000 / GATE_MS);

	// register byte offsets
	localparam logic [11:0] ADDR_CTRL       = 12'h000;
	localparam logic [11:0] ADDR_STATUS     = 12'h004;
	localparam logic [11:0] ADDR_REF_FREQ   = 12'h008;
	localparam logic [11:0] ADDR_MUTE_IN    = 12'h00C;
	localparam logic [11:0] ADDR_MUTE_PLAY  = 12'h010;
	localparam logic [11:0] ADDR_SOLO_IN    = 12'h014;
	localparam logic [11:0] ADDR_SOLO_PLAY  = 12'h018;
	localparam logic [11:0] ADDR_LOOPBACK   = 12'h01C;
	localparam logic [11:0] ADDR_ROUTE_SEL  = 12'h020;
	localparam logic [11:0] ADDR_ROUTE_DATA = 12'h024;
	localparam logic [11:0] ADDR_METER_SEL  = 12'h028;
	localparam logic [11:0] ADDR_METER_LVL  = 12'h02C;
	localparam logic [3:0]  ADDR_OUTLVL_PG  = 4'h1;

	// field positions
	localparam int CTRL_AUTO_BIT   = 0;
	localparam int CTRL_PREF_BIT   = 1;
	localparam int CTRL_SPEED_LSB  = 2;
	localparam int STAT_LOCK_BIT   = 0;
	localparam int STAT_REF_BIT    = 1;
	localparam int STAT_BUSY_BIT   = 2;
	localparam int STAT_PEND_BIT   = 3;
	localparam int STAT_OVR_BIT    = 4;
	localparam int ROUTE_PAN_LSB   = 16;
	localparam int ROUTE_ACT_BIT   = 24;

	typedef enum logic [1:0] {SPD_SINGLE, SPD_DOUBLE, SPD_QUAD} amx_speed_t;
	typedef enum logic {REF_INTERNAL, REF_WORD} amx_ref_t;

	typedef struct packed {
		logic                 play;
		logic [4:0]           chan;
		logic signed [DW-1:0] data;
	} amx_word_t;

endpackage

// >>> amx_mem.sv
/*
 * amx_mem: simple dual port RAM, one write and one registered read port.
 * Assumes write and read addresses are in range; no reset on contents.
 */
`timescale 1ns/100ps
module amx_mem #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 1024,
	parameter int AW    = $clog2(DEPTH)
)(
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             we,
	input  wire logic [AW-1:0]    waddr,
	input  wire logic [WIDTH-1:0] wdata,
	input  wire logic [AW-1:0]    raddr,
	output logic      [WIDTH-1:0] rdata
);

	logic [WIDTH-1:0] mem [0:DEPTH-1];

	generate
		if (WIDTH < 1 || DEPTH < 2 || (1 << AW) < DEPTH)
		begin : g_bad
			$error("amx_mem: bad geometry");
		end
	endgenerate

	always_ff @(posedge clk)
	begin
		if (we)
		begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rdata <= '0;
		end
		else
		begin
			rdata <= mem[raddr];
		end
	end

endmodule

// >>> amx_mixer.sv
/*
 * amx_mixer: time-multiplexed 56 x 28 audio matrix mixer with metering and
 * word clock reference monitor, controlled over an AHB-Lite slave port.
 * Assumes the sample stream is delivered while idle, before each frame_tick.
 */
// Implementation choices: the address map and the AHB-Lite register port.
// How it works
// - lock output is high while word clock edges keep arriving.
// - auto select with word preferred reports word once locked.
// - word clock edges counted over a gate give frequency in Hz.
// - 28 inputs and 28 playbacks can reach all 28 outputs.
// - every source-to-pair route stores its own gain word.
// - every route stores a pan that splits gain between pair halves.
// - record stream passes inputs unchanged unless looped back.
// - per output loopback sends that output's mix to record stream.
// - each of 84 channels keeps a peak and an RMS meter.
// - input and playback meters see samples before any gain.
// - output meters see final saturated output samples.
// - peak takes the maximum of each single sample, no smoothing.
// - mean square is slowly averaged, square root taken on readout.
// - full scale or clipped samples set a sticky overload bit.
// - mute and solo per input and playback gate its contributions.
// - each output has a level applied to its summed mix.
// - fourteen pairs each hold an independent stereo submix.
// - zero gain marks a route inactive and it adds nothing.
// - double speed drops eight optical channels, quad keeps twelve.
`timescale 1ns/100ps
module amx_mixer
	import amx_pkg::*;
#(
	parameter int LOCK_CYC = LOCK_CYCLES,
	parameter int GATE_CYC = GATE_CYCLES
)(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic      [31:0] hrdata,
	output logic             hresp,
	input  wire logic        wck_in,
	input  wire logic        frame_tick,
	input  wire logic        in_valid,
	input  wire amx_word_t   in_word,
	output logic             in_ready,
	output logic             out_valid,
	output amx_word_t        out_word,
	output logic             rec_valid,
	output amx_word_t        rec_word,
	output logic             ref_lock,
	output amx_ref_t         current_reference_status
);

	typedef enum logic [2:0] {ST_IDLE, ST_RUN, ST_DRAIN, ST_EMIT_L, ST_EMIT_R} amx_state_t;

	localparam logic signed [64:0] FS_POS = 65'sh7FFFFF;
	localparam logic signed [64:0] FS_NEG = -65'sh800000;
	localparam int LW = $clog2(LOCK_CYC + 1);
	localparam int GW = $clog2(GATE_CYC + 1);

	generate
		if (LOCK_CYC < 1 || GATE_CYC < 2)
		begin : g_bad
			$error("amx_mixer: timing parameters too small");
		end
	endgenerate

	// speed mode removes optical channels from the walk
	function automatic logic [4:0] next_ch(input logic [4:0] c, input amx_speed_t sp);
		if (sp == SPD_QUAD && c == CH_OPT_FIRST - 5'h01)
			return CH_SPDIF_FIRST;
		if (sp == SPD_DOUBLE && c == CH_OPT_DBL_FIRST - 5'h01)
			return CH_SPDIF_FIRST;
		return c + 5'h01;
	endfunction

	function automatic logic chan_on(input logic [4:0] c, input amx_speed_t sp);
		if (c > CH_LAST)
			return 1'b0;
		if (sp == SPD_QUAD)
			return !(c >= CH_OPT_FIRST && c <= CH_OPT_LAST);
		if (sp == SPD_DOUBLE)
			return !(c >= CH_OPT_DBL_FIRST && c <= CH_OPT_LAST);
		return c <= CH_LAST;
	endfunction

	function automatic logic [14:0] mag15(input logic signed [23:0] x);
		logic [23:0] a;
		a = x[23] ? 24'(-x) : 24'(x);
		if (x == 24'sh800000)
			return 15'h7FFF;
		return a[22:8];
	endfunction

	function automatic logic is_fs(input logic signed [23:0] x);
		return x == 24'sh7FFFFF || x == 24'sh800000;
	endfunction

	function automatic logic [29:0] ms_step(input logic [29:0] old, input logic [14:0] m);
		logic signed [31:0] diff;
		diff = $signed({2'b00, 30'(m) * 30'(m)}) - $signed({2'b00, old});
		return 30'($signed({2'b00, old}) + (diff >>> RMS_SHIFT));
	endfunction

	function automatic logic [14:0] isqrt30(input logic [29:0] v);
		logic [14:0] root;
		root = '0;
		for (int i = 14; i >= 0; i--)
		begin
			root[i] = 1'b1;
			if (30'(root) * 30'(root) > v)
				root[i] = 1'b0;
		end
		return root;
	endfunction

	// control registers
	logic              auto_ff, pref_word_ff, ovr_ff, pend_ff;
	amx_speed_t        speed_ff, speed_sh_ff;
	logic [1:0][27:0]  mute_ff, solo_ff, mask_sh_ff;
	logic [27:0]       loop_ff, loop_sh_ff;
	logic [15:0]       outlvl_ff    [0:N_CH-1];
	logic [15:0]       outlvl_sh_ff [0:N_CH-1];
	logic [9:0]        route_sel_ff, pend_addr_ff;
	logic [23:0]       pend_data_ff;
	logic [6:0]        meter_sel_ff;
	// bus state
	logic              dp_ff, dp_wr_ff, stall, wr_go, ap;
	logic [11:0]       dp_addr_ff;
	logic [31:0]       rd_val;
	// engine
	amx_state_t        st_ff;
	logic [3:0]        pair_ff;
	logic              sp_ff, vd_ff;
	logic [4:0]        sc_ff;
	logic [5:0]        sd_ff;
	logic signed [47:0] acc_l_ff, acc_r_ff;
	logic [23:0]       route_rd, samp_rd;
	logic              start, intake, last_src, contrib, emit_now, clip;
	logic [15:0]       gl, gr;
	logic [23:0]       gl_full, gr_full;
	logic signed [40:0] prod_l, prod_r;
	logic [4:0]        emit_ch, pair_step;
	logic signed [47:0] emit_acc;
	logic signed [64:0] y_full, y_sc;
	logic signed [23:0] y_sat;
	// meters
	logic [14:0]       pk_ff  [0:N_METER-1];
	logic              ovf_ff [0:N_METER-1];
	logic [29:0]       ms_ff  [0:N_METER-1];
	logic [6:0]        pre_idx, post_idx;
	logic              mtr_clr;
	// word clock
	logic              wck_s1_ff, wck_s2_ff, wck_s3_ff, wck_edge, lock_ff;
	logic [LW-1:0]     lock_tmr_ff;
	logic [GW-1:0]     gate_ff;
	logic [19:0]       edges_ff;
	logic [31:0]       freq_ff;

	// ---------------- AHB-Lite slave ----------------
	assign ap        = hsel && hready && htrans[1];
	// a second route write must wait until the first has reached the table
	assign stall     = dp_ff && dp_wr_ff && dp_addr_ff == ADDR_ROUTE_DATA && pend_ff;
	assign hreadyout = !stall;
	assign hresp     = 1'b0;
	assign wr_go     = dp_ff && dp_wr_ff && !stall;
	assign mtr_clr   = ap && !hwrite && haddr[11:0] == ADDR_METER_LVL;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dp_ff      <= 1'b0;
			dp_wr_ff   <= 1'b0;
			dp_addr_ff <= '0;
			hrdata     <= '0;
		end
		else if (hready)
		begin
			dp_ff      <= ap;
			dp_wr_ff   <= ap && hwrite;
			dp_addr_ff <= haddr[11:0];
			if (ap && !hwrite)
				hrdata <= rd_val;
		end
	end

	always_comb
	begin
		rd_val = '0;
		unique case (haddr[11:0])
			ADDR_CTRL:       rd_val = 32'({speed_ff, pref_word_ff, auto_ff});
			ADDR_STATUS:     rd_val = 32'({ovr_ff, pend_ff, st_ff != ST_IDLE,
					current_reference_status == REF_WORD, lock_ff});
			ADDR_REF_FREQ:   rd_val = (current_reference_status == REF_WORD) ? freq_ff : '0;
			ADDR_MUTE_IN:    rd_val = 32'(mute_ff[0]);
			ADDR_MUTE_PLAY:  rd_val = 32'(mute_ff[1]);
			ADDR_SOLO_IN:    rd_val = 32'(solo_ff[0]);
			ADDR_SOLO_PLAY:  rd_val = 32'(solo_ff[1]);
			ADDR_LOOPBACK:   rd_val = 32'(loop_ff);
			ADDR_ROUTE_SEL:  rd_val = 32'(route_sel_ff);
			ADDR_ROUTE_DATA: rd_val = 32'({pend_data_ff[15:0] != 16'h0000, pend_data_ff});
			ADDR_METER_SEL:  rd_val = 32'(meter_sel_ff);
			ADDR_METER_LVL:  rd_val = (meter_sel_ff < 7'(N_METER)) ? {1'b0,
					isqrt30(ms_ff[meter_sel_ff]), ovf_ff[meter_sel_ff],
					pk_ff[meter_sel_ff]} : '0;
			default:
				if (haddr[11:8] == ADDR_OUTLVL_PG && haddr[7:2] < 6'(N_CH))
					rd_val = 32'(outlvl_ff[haddr[6:2]]);
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			auto_ff      <= 1'b0;
			pref_word_ff <= 1'b0;
			speed_ff     <= SPD_SINGLE;
			mute_ff      <= '0;
			solo_ff      <= '0;
			loop_ff      <= '0;
			route_sel_ff <= '0;
			meter_sel_ff <= '0;
			for (int i = 0; i < N_CH; i++)
				outlvl_ff[i] <= OUTLVL_RST;
		end
		else if (wr_go)
		begin
			unique case (dp_addr_ff)
				ADDR_CTRL:
				begin
					auto_ff      <= hwdata[CTRL_AUTO_BIT];
					pref_word_ff <= hwdata[CTRL_PREF_BIT];
					speed_ff     <= amx_speed_t'(hwdata[CTRL_SPEED_LSB +: 2]);
				end
				ADDR_MUTE_IN:   mute_ff[0] <= hwdata[27:0];
				ADDR_MUTE_PLAY: mute_ff[1] <= hwdata[27:0];
				ADDR_SOLO_IN:   solo_ff[0] <= hwdata[27:0];
				ADDR_SOLO_PLAY: solo_ff[1] <= hwdata[27:0];
				ADDR_LOOPBACK:  loop_ff    <= hwdata[27:0];
				ADDR_ROUTE_SEL: route_sel_ff <= hwdata[9:0];
				ADDR_METER_SEL: meter_sel_ff <= hwdata[6:0];
				default:
					if (dp_addr_ff[11:8] == ADDR_OUTLVL_PG && dp_addr_ff[7:2] < 6'(N_CH))
						outlvl_ff[dp_addr_ff[6:2]] <= hwdata[15:0];
			endcase
		end
	end

	// route writes are held and committed only while the engine is idle
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pend_ff      <= 1'b0;
			pend_addr_ff <= '0;
			pend_data_ff <= '0;
		end
		else if (wr_go && dp_addr_ff == ADDR_ROUTE_DATA)
		begin
			pend_ff      <= 1'b1;
			pend_addr_ff <= route_sel_ff;
			pend_data_ff <= hwdata[23:0];
		end
		else if (st_ff == ST_IDLE)
			pend_ff <= 1'b0;
	end

	// frame overrun: set wins over the write-one clear
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			ovr_ff <= 1'b0;
		else if (frame_tick && st_ff != ST_IDLE)
			ovr_ff <= 1'b1;
		else if (wr_go && dp_addr_ff == ADDR_STATUS && hwdata[STAT_OVR_BIT])
			ovr_ff <= 1'b0;
	end

	// ---------------- frame engine ----------------
	assign start    = frame_tick && st_ff == ST_IDLE;
	assign in_ready = st_ff == ST_IDLE;
	assign intake   = in_valid && in_ready && chan_on(in_word.chan, speed_sh_ff);
	assign last_src = sp_ff && sc_ff == CH_LAST;
	assign pair_step = next_ch({pair_ff, 1'b1}, speed_sh_ff);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			speed_sh_ff <= SPD_SINGLE;
			mask_sh_ff  <= '1;
			loop_sh_ff  <= '0;
			for (int i = 0; i < N_CH; i++)
				outlvl_sh_ff[i] <= OUTLVL_RST;
		end
		else if (start)
		begin
			speed_sh_ff <= speed_ff;
			for (int p = 0; p < 2; p++)
				mask_sh_ff[p] <= ~mute_ff[p] & (|solo_ff ? solo_ff[p] : '1);
			loop_sh_ff <= loop_ff;
			outlvl_sh_ff <= outlvl_ff;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			st_ff   <= ST_IDLE;
			pair_ff <= '0;
			sp_ff   <= 1'b0;
			sc_ff   <= '0;
			vd_ff   <= 1'b0;
			sd_ff   <= '0;
		end
		else
		begin
			vd_ff <= st_ff == ST_RUN;
			sd_ff <= {sp_ff, sc_ff};
			unique case (st_ff)
				ST_IDLE:
					if (start)
					begin
						st_ff   <= ST_RUN;
						pair_ff <= '0;
						sp_ff   <= 1'b0;
						sc_ff   <= '0;
					end
				ST_RUN:
					if (last_src)
						st_ff <= ST_DRAIN;
					else if (sc_ff == CH_LAST)
					begin
						sp_ff <= 1'b1;
						sc_ff <= '0;
					end
					else
						sc_ff <= next_ch(sc_ff, speed_sh_ff);
				ST_DRAIN:  st_ff <= ST_EMIT_L;
				ST_EMIT_L: st_ff <= ST_EMIT_R;
				ST_EMIT_R:
					if (pair_ff == PAIR_LAST)
						st_ff <= ST_IDLE;
					else
					begin
						pair_ff <= pair_step[4:1];
						sp_ff   <= 1'b0;
						sc_ff   <= '0;
						st_ff   <= ST_RUN;
					end
			endcase
		end
	end

	// route table: one gain and pan word per source and output pair
	amx_mem #(.WIDTH(24), .DEPTH(1024)) u_route (
		.clk   (hclk),
		.rst_n (hresetn),
		.we    (pend_ff && st_ff == ST_IDLE),
		.waddr (pend_addr_ff),
		.wdata (pend_data_ff),
		.raddr ({pair_ff, sp_ff, sc_ff}),
		.rdata (route_rd)
	);

	amx_mem #(.WIDTH(24), .DEPTH(64)) u_samp (
		.clk   (hclk),
		.rst_n (hresetn),
		.we    (intake),
		.waddr ({in_word.play, in_word.chan}),
		.wdata (in_word.data),
		.raddr ({sp_ff, sc_ff}),
		.rdata (samp_rd)
	);

	assign contrib = vd_ff && route_rd[15:0] != 16'h0000 && mask_sh_ff[sd_ff[5]][sd_ff[4:0]];
	assign gl_full = 24'(route_rd[15:0]) * 24'(PAN_MAX - route_rd[ROUTE_PAN_LSB +: 8]);
	assign gr_full = 24'(route_rd[15:0]) * 24'(route_rd[ROUTE_PAN_LSB +: 8]);
	assign gl      = gl_full[23:8];
	assign gr      = gr_full[23:8];
	assign prod_l  = 41'($signed(samp_rd)) * 41'($signed({1'b0, gl}));
	assign prod_r  = 41'($signed(samp_rd)) * 41'($signed({1'b0, gr}));

	// 48 bits hold 56 full scale terms at maximum gain without wrapping
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			acc_l_ff <= '0;
			acc_r_ff <= '0;
		end
		else if (st_ff == ST_EMIT_R)
		begin
			acc_l_ff <= '0;
			acc_r_ff <= '0;
		end
		else if (contrib)
		begin
			acc_l_ff <= acc_l_ff + 48'(prod_l >>> GAIN_FRAC);
			acc_r_ff <= acc_r_ff + 48'(prod_r >>> GAIN_FRAC);
		end
	end

	assign emit_now = st_ff == ST_EMIT_L || st_ff == ST_EMIT_R;
	assign emit_ch  = {pair_ff, st_ff == ST_EMIT_R};
	assign emit_acc = (st_ff == ST_EMIT_R) ? acc_r_ff : acc_l_ff;
	assign y_full   = 65'(emit_acc) * 65'($signed({1'b0, outlvl_sh_ff[emit_ch]}));
	assign y_sc     = y_full >>> GAIN_FRAC;
	assign clip     = y_sc > FS_POS || y_sc < FS_NEG;
	assign y_sat    = (y_sc > FS_POS) ? 24'sh7FFFFF :
		(y_sc < FS_NEG) ? 24'sh800000 : 24'(y_sc);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			out_valid <= 1'b0;
			out_word  <= '0;
		end
		else
		begin
			out_valid <= emit_now;
			if (emit_now)
				out_word <= '{play: 1'b0, chan: emit_ch, data: y_sat};
		end
	end

	// record path: inputs pass bit-exact, looped outputs replace them
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			rec_valid <= 1'b0;
			rec_word  <= '0;
		end
		else if (intake && !in_word.play && !loop_sh_ff[in_word.chan])
		begin
			rec_valid <= 1'b1;
			rec_word  <= in_word;
		end
		else if (emit_now && loop_sh_ff[emit_ch])
		begin
			rec_valid <= 1'b1;
			rec_word  <= '{play: 1'b0, chan: emit_ch, data: y_sat};
		end
		else
			rec_valid <= 1'b0;
	end

	// ---------------- meters ----------------
	assign pre_idx  = in_word.play ? 7'(in_word.chan) + PLAY_METER_BASE : 7'(in_word.chan);
	assign post_idx = POST_METER_BASE + 7'(emit_ch);

	// peak and overload clear on read; an update in the same cycle wins
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			for (int i = 0; i < N_METER; i++)
			begin
				pk_ff[i]  <= '0;
				ovf_ff[i] <= 1'b0;
				ms_ff[i]  <= '0;
			end
		end
		else
		begin
			if (mtr_clr && meter_sel_ff < 7'(N_METER))
			begin
				pk_ff[meter_sel_ff]  <= '0;
				ovf_ff[meter_sel_ff] <= 1'b0;
			end
			if (intake)
			begin
				if (mag15(in_word.data) > pk_ff[pre_idx])
					pk_ff[pre_idx] <= mag15(in_word.data);
				if (is_fs(in_word.data))
					ovf_ff[pre_idx] <= 1'b1;
				ms_ff[pre_idx] <= ms_step(ms_ff[pre_idx], mag15(in_word.data));
			end
			if (emit_now)
			begin
				if (mag15(y_sat) > pk_ff[post_idx])
					pk_ff[post_idx] <= mag15(y_sat);
				if (clip || is_fs(y_sat))
					ovf_ff[post_idx] <= 1'b1;
				ms_ff[post_idx] <= ms_step(ms_ff[post_idx], mag15(y_sat));
			end
		end
	end

	// ---------------- word clock reference ----------------
	assign wck_edge = wck_s2_ff && !wck_s3_ff;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wck_s1_ff <= 1'b0;
			wck_s2_ff <= 1'b0;
			wck_s3_ff <= 1'b0;
		end
		else
		begin
			wck_s1_ff <= wck_in;
			wck_s2_ff <= wck_s1_ff;
			wck_s3_ff <= wck_s2_ff;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			lock_tmr_ff <= '0;
			lock_ff     <= 1'b0;
		end
		else
		begin
			if (wck_edge)
				lock_tmr_ff <= LW'(LOCK_CYC);
			else if (lock_tmr_ff != '0)
				lock_tmr_ff <= lock_tmr_ff - LW'(1);
			lock_ff <= wck_edge || lock_tmr_ff > LW'(1);
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			gate_ff  <= '0;
			edges_ff <= '0;
			freq_ff  <= '0;
		end
		else if (gate_ff == GW'(GATE_CYC - 1))
		begin
			gate_ff  <= '0;
			edges_ff <= 20'(wck_edge);
			freq_ff  <= 32'(32'(edges_ff) * FREQ_SCALE);
		end
		else
		begin
			gate_ff  <= gate_ff + GW'(1);
			edges_ff <= edges_ff + 20'(wck_edge);
		end
	end

	assign ref_lock = lock_ff;
	assign current_reference_status = (auto_ff && pref_word_ff && lock_ff) ? REF_WORD
		: REF_INTERNAL;

endmodule

// >>> amx_mixer_properties.sv
/* amx_mixer_properties: port checks on the mixer, bound at the foot.
   assumes the single hclk domain and the designer's frame walk. */
`timescale 1ns/100ps
module amx_mixer_properties
	import amx_pkg::*;
#(
	parameter int LOCK_CYC = LOCK_CYCLES
)(
	input wire logic      hclk,
	input wire logic      hresetn,
	input wire logic      hreadyout,
	input wire logic      frame_tick,
	input wire logic      in_valid,
	input wire amx_word_t in_word,
	input wire logic      in_ready,
	input wire logic      out_valid,
	input wire amx_word_t out_word,
	input wire logic      rec_valid,
	input wire amx_word_t rec_word,
	input wire logic      wck_in,
	input wire logic      ref_lock,
	input wire amx_ref_t  current_reference_status
);
	logic        wck_q_ff;
	logic [31:0] quiet_ff;
	// cycles since the pin last moved; margin covers the synchroniser
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wck_q_ff <= 1'b0;
			quiet_ff <= 32'h0;
		end
		else
		begin
			wck_q_ff <= wck_in;
			quiet_ff <= (wck_in != wck_q_ff) ? 32'h0 : quiet_ff + 32'h1;
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_lock_lapse: assert property (quiet_ff > LOCK_CYC + 8 |-> !ref_lock)
		else $error("lock held without word clock");
	a_word_locked: assert property (current_reference_status == REF_WORD |-> ref_lock || $past(ref_lock))
		else $error("word reference without lock");
	a_rec_exact: assert property (in_valid && in_ready && !in_word.play && in_word.chan < 5'h0A
		|=> rec_valid && rec_word == $past(in_word)) else $error("record word altered");
	a_loop_rec: assert property (out_valid && rec_valid |-> rec_word.data == out_word.data)
		else $error("loopback word differs");
	a_out_chan: assert property (out_valid |-> !out_word.play && out_word.chan <= CH_LAST)
		else $error("output channel out of range");
	a_pair_right: assert property (out_valid && !out_word.chan[0]
		|=> out_valid && out_word.chan == $past(out_word.chan) + 5'h1) else $error("pair split");
	a_tick_busy: assert property (frame_tick && in_ready |=> !in_ready)
		else $error("frame did not start");
	a_frame_ends: assert property ($fell(in_ready) |-> ##[1:900] in_ready)
		else $error("frame too long");
	a_wait_ends: assert property (!hreadyout |-> ##[1:900] hreadyout)
		else $error("route write stalled");
	c_out: cover property (out_valid && out_word.chan == CH_LAST);
	c_stall: cover property (!hreadyout);
	c_word: cover property (current_reference_status == REF_WORD);
endmodule

bind amx_mixer amx_mixer_properties #(.LOCK_CYC(LOCK_CYC)) amx_mixer_properties_inst (
	.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .frame_tick(frame_tick),
	.in_valid(in_valid), .in_word(in_word), .in_ready(in_ready), .out_valid(out_valid),
	.out_word(out_word), .rec_valid(rec_valid), .rec_word(rec_word), .wck_in(wck_in),
	.ref_lock(ref_lock), .current_reference_status(current_reference_status));

// >>> amx_host_model.sv
/* amx_host_model: sources feeding the sample intake.
   assumes in_ready is the engine's idle level. */
`timescale 1ns/100ps
module amx_host_model
	import amx_pkg::*;
(
	input  wire logic hclk,
	input  wire logic in_ready,
	output logic      in_valid,
	output amx_word_t in_word
);
	initial
	begin
		in_valid = 1'b0;
		in_word  = '0;
	end
	task automatic send(input amx_word_t w, input int gap);
		repeat (gap) @(posedge hclk);
		in_valid <= 1'b1;
		in_word  <= w;
		@(posedge hclk iff in_ready);
		in_valid <= 1'b0;
		// a released word must not pass for the last one
		in_word  <= ~w;
	endtask
endmodule

// >>> amx_mixer_tb.sv
/* amx_mixer_tb: routes, mixes and meters checked against a model.
   assumes shortened lock and gate counts. */
`timescale 1ns/100ps
module amx_mixer_tb import amx_pkg::*;;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, wck_in, wck_run, frame_tick;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        in_valid, in_ready, out_valid, rec_valid, ref_lock;
	amx_word_t   in_word, out_word, rec_word;
	amx_ref_t    cur_ref;
	int          seed = 57202, mismatches = 0, total_checks = 0, cyc = 0, spd, a;
	int          smp[56], gain[14][56], pan[14][56], lvl[28];
	logic [27:0] mute_in, mute_pl, lb;
	amx_mixer #(.LOCK_CYC(50), .GATE_CYC(200)) amx_mixer_inst (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
		.hresp(hresp), .wck_in(wck_in), .frame_tick(frame_tick), .in_valid(in_valid),
		.in_word(in_word), .in_ready(in_ready), .out_valid(out_valid), .out_word(out_word),
		.rec_valid(rec_valid), .rec_word(rec_word), .ref_lock(ref_lock),
		.current_reference_status(cur_ref));
	amx_host_model amx_host_model_inst (.hclk(hclk), .in_ready(in_ready), .in_valid(in_valid),
		.in_word(in_word));
	initial
	begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end
	always @(posedge hclk)
	begin
		cyc <= cyc + 1;
		wck_in <= wck_run && (cyc % 10 < 5);
		if (cyc == 40000)
		begin
			mismatches++;
			stop_test();
		end
	end
	task automatic stop_test();
		if (mismatches == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("MISMATCH at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [11:0] ad, input logic [31:0] d);
		@(posedge hclk);
		hsel   <= 1'b1;
		haddr  <= {20'h0, ad};
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge hclk iff hreadyout);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk iff hreadyout);
		rd = hrdata;
	endtask
	function automatic bit en(input int ch);
		return spd == 2 ? !(ch inside {[10:25]}) : spd == 1 ? !(ch inside {[18:25]}) : 1;
	endfunction
	function automatic logic [31:0] rword(input int p, input int s);
		return {7'h0, gain[p][s] != 0, 8'(pan[p][s]), 16'(gain[p][s])};
	endfunction
	function automatic logic [31:0] model(input int c);
		longint acc = 0;
		for (int s = 0; s < 56; s++)
			if (en(s % 28) && !(s < 28 ? mute_in[s] : mute_pl[s - 28]))
				acc += (longint'(smp[s]) * ((gain[c / 2][s]
					* (c % 2 ? pan[c / 2][s] : 255 - pan[c / 2][s])) >> 8)) >>> 15;
		acc = (acc * lvl[c]) >>> 15;
		acc = acc > 64'sh7FFFFF ? 64'sh7FFFFF : acc < -64'sh800000 ? -64'sh800000 : acc;
		return {8'h00, acc[23:0]};
	endfunction
	task automatic frame();
		amx_word_t w;
		logic [31:0] e[28];
		bus(1, 12'h028, 0);
		bus(0, 12'h02C, 0);
		for (int s = 0; s < 56; s++)
		begin
			w = {s >= 28, 5'(s % 28), (s == 0 && spd == 1) ? 24'h7FFFFF : 24'($random(seed))};
			smp[s] = int'(w.data);
			amx_host_model_inst.send(w, 1 + s % 3);
		end
		@(posedge hclk);
		frame_tick <= 1'b1;
		@(posedge hclk);
		frame_tick <= 1'b0;
		for (int c = 0; c < 28; c++)
			e[c] = model(c);
		fork
			for (int c = 0; c < 28; c++)
				if (en(c))
				begin
					@(negedge hclk iff out_valid);
					chk({27'h0, out_word.chan}, c);
					chk({8'h0, out_word.data}, e[c]);
					if (lb[c])
						chk({rec_valid, rec_word.data}, {1'b1, out_word.data});
				end
			begin
				gain[13][55] = (gain[13][55] + 1) & 32'hFFFF;
				repeat (2) bus(1, 12'h024, rword(13, 55));
			end
		join
		a = smp[0] < 0 ? -smp[0] : smp[0];
		bus(0, 12'h02C, 0);
		chk(rd & 32'hFFFF, {16'h0, a == 32'h7FFFFF, 15'(a >> 8)});
	endtask
	initial
	begin
		{hsel, haddr, htrans, hwrite, hwdata, wck_run, frame_tick, hresetn} = '0;
		hsize = 3'h2;
		spd = 0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		bus(0, 12'h000, 0);
		chk(rd, 0);
		bus(0, 12'h104, 0);
		chk(rd, 32'h8000);
		bus(1, 12'h200, 32'hFFFF);
		bus(0, 12'h200, 0);
		chk(rd, 0);
		for (int p = 0; p < 14; p++)
			for (int s = 0; s < 56; s++)
			begin
				gain[p][s] = ($random(seed) & 3) == 0 ? $random(seed) & 32'hFFFF : 0;
				pan[p][s] = $random(seed) & 32'hFF;
				bus(1, 12'h020, {22'h0, 4'(p), s >= 28, 5'(s % 28)});
				bus(1, 12'h024, rword(p, s));
			end
		bus(0, 12'h024, 0);
		chk(rd, rword(13, 55));
		for (int c = 0; c < 28; c++)
		begin
			lvl[c] = $random(seed) & 32'hFFFF;
			bus(1, 12'h100 + 12'(4 * c), lvl[c]);
		end
		{mute_in, mute_pl, lb} = {56'h0, 28'h8000000};
		bus(1, 12'h01C, {4'h0, lb});
		for (spd = 0; spd < 3; spd++)
		begin
			bus(1, 12'h000, spd << 2);
			frame();
			mute_in = $random(seed);
			mute_pl = $random(seed);
			bus(1, 12'h00C, {4'h0, mute_in});
			bus(1, 12'h010, {4'h0, mute_pl});
			frame();
		end
		bus(1, 12'h000, 32'h3);
		wck_run <= 1'b1;
		repeat (600) @(posedge hclk);
		bus(0, 12'h004, 0);
		chk(rd & 3, 3);
		bus(0, 12'h008, 0);
		chk(rd >= 190 && rd <= 210, 1);
		wck_run <= 1'b0;
		repeat (100) @(posedge hclk);
		bus(0, 12'h004, 0);
		chk(rd & 3, 0);
		stop_test();
	end
endmodule
